// File: pkg/ctc_pkg.sv
// Package: constants and types shared by the cascadable counter unit
package ctc_pkg;

  // Clock rates and on-board source divider
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned SRC_HZ = 4_000_000;
  localparam int unsigned SRC_DIV = CLK_HZ / SRC_HZ;
  localparam logic [4:0] SRC_DIV_LAST = 5'(SRC_DIV - 1);

  // Register byte offsets
  localparam logic [7:0] OFF_CNT0 = 8'h00;
  localparam logic [7:0] OFF_CNT1 = 8'h04;
  localparam logic [7:0] OFF_CNT2 = 8'h08;
  localparam logic [7:0] OFF_CTRL = 8'h0C;
  localparam logic [7:0] OFF_OUTS = 8'h10;
  localparam logic [7:0] OFF_STAT = 8'h14;
  localparam logic [7:0] OFF_MASK = 8'h18;
  localparam logic [7:0] OFF_CNT32 = 8'h1C;

  // Control field positions
  localparam int unsigned MODE0_LSB = 0;
  localparam int unsigned MODE1_LSB = 2;
  localparam int unsigned MODE2_LSB = 4;
  localparam int unsigned GATE_BIT = 8;
  localparam int unsigned CTRL_W = 9;

  // Status and mask bit positions
  localparam int unsigned ST_CU = 0;
  localparam int unsigned ST_OVR = 1;
  localparam int unsigned ST_TC0 = 2;
  localparam int unsigned STAT_W = 5;

  // Values after reset
  localparam logic [8:0] CTRL_RST = 9'h000;
  localparam logic [4:0] MASK_RST = 5'h00;
  localparam logic [4:0] STAT_RST = 5'h00;
  localparam logic [15:0] RELOAD_RST = 16'h0000;

  // Counting modes of one stage
  typedef enum logic [1:0] {
    CTC_MODE_TERM = 2'b00,
    CTC_MODE_ONESHOT = 2'b01,
    CTC_MODE_RATE = 2'b10,
    CTC_MODE_RSVD = 2'b11
  } ctc_mode_t;

  // Static jumper chaining choices
  typedef enum logic [1:0] {
    CTC_CFG_CASCADE = 2'b00,
    CTC_CFG_EXT32 = 2'b01,
    CTC_CFG_GATE32 = 2'b10,
    CTC_CFG_RSVD = 2'b11
  } ctc_cfg_t;

  // Stage sequencing states
  typedef enum logic [1:0] {
    CTC_ST_IDLE = 2'b00,
    CTC_ST_LOAD = 2'b01,
    CTC_ST_RUN = 2'b10
  } ctc_stage_st_t;

endpackage

// File: design/ctc_prescale.sv
// On-board counting source: one-cycle tick at the 4 MHz rate
`timescale 1ns/1ps
`default_nettype none
module ctc_prescale (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Tick out
  output logic tick
);

  logic [4:0] div;
  logic [4:0] next_div;
  logic next_tick;

  // Wrap the divider once per source period
  always_comb begin
    next_tick = (div == ctc_pkg::SRC_DIV_LAST);
    next_div = next_tick ? 5'h00 : 5'(div + 5'h01);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div <= 5'h00;
      tick <= 1'b0;
    end else begin
      div <= next_div;
      tick <= next_tick;
    end
  end

endmodule // ctc_prescale
`default_nettype wire

// File: design/ctc_stage.sv
// One 16-bit down-counting stage with terminal, one-shot and rate modes
`timescale 1ns/1ps
`default_nettype none
module ctc_stage (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Counting source and gate
  input wire logic tick,
  input wire logic gate,
  input wire logic gate_rise,
  // Programming
  input wire ctc_pkg::ctc_mode_t mode,
  input wire logic load,
  input wire logic [15:0] reload,
  // State out
  output logic [15:0] count,
  output logic out,
  output logic tc
);

  ctc_pkg::ctc_stage_st_t st;
  ctc_pkg::ctc_stage_st_t next_st;
  logic [15:0] next_count;
  logic next_out;
  logic next_tc;
  logic is_shot;
  logic is_rate;

  assign is_shot = (mode == ctc_pkg::CTC_MODE_ONESHOT);
  assign is_rate = (mode == ctc_pkg::CTC_MODE_RATE);

  // Next count, output level and terminal pulse
  always_comb begin
    next_st = st;
    next_count = count;
    next_out = out;
    next_tc = 1'b0;
    if (load) begin
      next_st = is_shot ? ctc_pkg::CTC_ST_IDLE : ctc_pkg::CTC_ST_LOAD;
      next_out = is_shot | is_rate;
    end else begin
      case (st)
        ctc_pkg::CTC_ST_IDLE: begin
          // One-shot waits for a gate edge as its trigger
          if (is_shot && gate_rise) begin
            next_st = ctc_pkg::CTC_ST_LOAD;
          end
        end
        ctc_pkg::CTC_ST_LOAD: begin
          if (tick) begin
            next_count = reload;
            next_st = ctc_pkg::CTC_ST_RUN;
            if (is_shot) begin
              next_out = 1'b0;
            end
          end
        end
        ctc_pkg::CTC_ST_RUN: begin
          if ((is_shot || is_rate) && gate_rise) begin
            next_st = ctc_pkg::CTC_ST_LOAD; // Retrigger restarts the count
          end else if (is_rate && !gate) begin
            next_out = 1'b1; // Gate low holds rate output high
          end else if (tick && (gate || is_shot)) begin
            next_count = 16'(count - 16'h0001);
            if (count == 16'h0001) begin
              next_tc = 1'b1;
              next_out = 1'b1;
              if (is_rate) begin
                next_count = reload; // Rate mode reloads and keeps going
              end else begin
                next_st = ctc_pkg::CTC_ST_IDLE;
              end
            end else if (is_rate && count == 16'h0002) begin
              next_out = 1'b0; // One source period low per cycle
            end
          end
        end
        default: next_st = ctc_pkg::CTC_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= ctc_pkg::CTC_ST_IDLE;
      count <= ctc_pkg::RELOAD_RST;
      out <= 1'b0;
      tc <= 1'b0;
    end else begin
      st <= next_st;
      count <= next_count;
      out <= next_out;
      tc <= next_tc;
    end
  end

endmodule // ctc_stage
`default_nettype wire

// File: design/ctc_unit.sv
// Three-stage jumper-chained counter unit with APB registers
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
module ctc_unit (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Static jumpers
  input wire logic [1:0] chain_jumper,
  input wire logic output_route_jumper,
  // External counter connector
  input wire logic external_counter_connector_clk,
  input wire logic external_counter_connector_gate,
  output logic external_counter_connector_out,
  // Interrupt
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Rising edge of a level against its previous sample
  function automatic logic rise(input logic now, input logic prev);
    rise = now & ~prev;
  endfunction

  // Merge write data into a 32-bit word under byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    merge = r;
  endfunction

  // Pick a mode field out of the control word
  function automatic ctc_pkg::ctc_mode_t mode_of(input logic [8:0] c,
                                                 input int unsigned lsb);
    mode_of = ctc_pkg::ctc_mode_t'(c[lsb +: 2]);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [8:0] ctrl;
  logic [8:0] next_ctrl;
  logic [4:0] mask;
  logic [4:0] next_mask;
  logic [4:0] stat;
  logic [4:0] next_stat;
  logic [15:0] reload [3];
  logic [15:0] next_reload [3];
  logic [2:0] load;
  logic [1:0] outs;
  logic [1:0] next_outs;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic [2:0] out_prev;
  logic ext_clk_prev;
  logic ext_gate_prev;
  logic gate_prev;
  logic [2:0] tick;
  logic [2:0] gate;
  logic [2:0] gate_rise;
  logic [2:0] out;
  logic [2:0] tc;
  logic [15:0] count [3];
  logic src_tick;
  logic sw_gate;
  logic sw_gate_rise;
  logic ext_clk_rise;
  logic ext_gate_rise;
  logic wr;
  logic setup;
  logic [4:0] ev;
  logic [4:0] clr;
  logic is32;
  logic conn_out;
  ctc_pkg::ctc_cfg_t cfg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  // Zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign setup = psel & ~penable;
  assign wr = psel & penable & pwrite;

  // Read data and error are latched in setup so they come from flops
  always_comb begin
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    if (setup) begin
      case (paddr)
        ctc_pkg::OFF_CNT0: next_prdata = {16'h0000, count[0]};
        ctc_pkg::OFF_CNT1: next_prdata = {16'h0000, count[1]};
        ctc_pkg::OFF_CNT2: next_prdata = {16'h0000, count[2]};
        ctc_pkg::OFF_CTRL: next_prdata = {23'h000000, ctrl};
        ctc_pkg::OFF_OUTS: next_prdata = {30'h00000000, outs};
        ctc_pkg::OFF_STAT: next_prdata = {27'h0000000, stat};
        ctc_pkg::OFF_MASK: next_prdata = {27'h0000000, mask};
        ctc_pkg::OFF_CNT32: next_prdata = {count[2], count[1]};
        default: next_pslverr = 1'b1; // Unmapped address
      endcase
    end else begin
      next_prdata = prdata;
      next_pslverr = pslverr;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Programming registers

  // Reload words, control and mask take writes under byte strobes
  always_comb begin
    logic [31:0] w;
    w = 32'h0000_0000;
    next_ctrl = ctrl;
    next_mask = mask;
    load = 3'b000;
    for (int i = 0; i < 3; i++) begin
      next_reload[i] = reload[i];
    end
    if (wr) begin
      case (paddr)
        ctc_pkg::OFF_CNT0, ctc_pkg::OFF_CNT1, ctc_pkg::OFF_CNT2: begin
          for (int i = 0; i < 3; i++) begin
            if (paddr == 8'(4 * i)) begin
              w = merge({16'h0000, reload[i]}, pwdata, pstrb);
              next_reload[i] = w[15:0];
              load[i] = 1'b1; // New count arms the stage
            end
          end
        end
        ctc_pkg::OFF_CTRL: begin
          w = merge({23'h000000, ctrl}, pwdata, pstrb);
          next_ctrl = w[8:0];
        end
        ctc_pkg::OFF_MASK: begin
          w = merge({27'h0000000, mask}, pwdata, pstrb);
          next_mask = w[4:0];
        end
        default: w = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= ctc_pkg::CTRL_RST;
      mask <= ctc_pkg::MASK_RST;
      for (int i = 0; i < 3; i++) begin
        reload[i] <= ctc_pkg::RELOAD_RST;
      end
    end else begin
      ctrl <= next_ctrl;
      mask <= next_mask;
      for (int i = 0; i < 3; i++) begin
        reload[i] <= next_reload[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection of counting sources and gates

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_prev <= 3'b000;
      ext_clk_prev <= 1'b0;
      ext_gate_prev <= 1'b0;
      gate_prev <= 1'b0;
    end else begin
      out_prev <= out;
      ext_clk_prev <= external_counter_connector_clk;
      ext_gate_prev <= external_counter_connector_gate;
      gate_prev <= sw_gate;
    end
  end

  assign sw_gate = ctrl[ctc_pkg::GATE_BIT];
  assign sw_gate_rise = rise(sw_gate, gate_prev);
  assign ext_clk_rise = rise(external_counter_connector_clk, ext_clk_prev);
  assign ext_gate_rise = rise(external_counter_connector_gate,
                              ext_gate_prev);

  ////////////////////////////////////////////////////////////////////////////
  // Jumper routing of clocks and gates

  // Jumpers are static; a change while counting gives undefined counts
  assign cfg = ctc_pkg::ctc_cfg_t'(chain_jumper);
  assign is32 = (cfg == ctc_pkg::CTC_CFG_EXT32) ||
                (cfg == ctc_pkg::CTC_CFG_GATE32);

  always_comb begin
    // Stage 0 always runs from the on-board source
    tick[0] = src_tick;
    gate[0] = sw_gate;
    gate_rise[0] = sw_gate_rise;
    // Stage 2 is clocked by stage 1 in every setting
    tick[2] = rise(out[1], out_prev[1]);
    gate[2] = sw_gate;
    gate_rise[2] = sw_gate_rise;
    case (cfg)
      ctc_pkg::CTC_CFG_EXT32: begin
        tick[1] = ext_clk_rise;
        gate[1] = external_counter_connector_gate;
        gate_rise[1] = ext_gate_rise;
        gate[2] = 1'b1; // High half follows low half only
        gate_rise[2] = 1'b0;
      end
      ctc_pkg::CTC_CFG_GATE32: begin
        tick[1] = rise(out[0], out_prev[0]);
        gate[1] = external_counter_connector_gate;
        gate_rise[1] = ext_gate_rise;
        gate[2] = 1'b1;
        gate_rise[2] = 1'b0;
      end
      default: begin
        tick[1] = rise(out[0], out_prev[0]);
        gate[1] = sw_gate;
        gate_rise[1] = sw_gate_rise;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counting source and stages

  ctc_prescale u_src (
    .pclk(pclk),
    .presetn(presetn),
    .tick(src_tick)
  );

  // Identical stages; only the routing above differs per setting
  for (genvar g = 0; g < 3; g++) begin : g_stage
    ctc_stage u_stage (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick[g]),
      .gate(gate[g]),
      .gate_rise(gate_rise[g]),
      .mode(mode_of(ctrl, 2 * g)),
      .load(load[g]),
      .reload(reload[g]),
      .count(count[g]),
      .out(out[g]),
      .tc(tc[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output capture and connector

  // Stage 1 and 2 outputs sampled each cycle for software
  always_comb begin
    next_outs = {out[2], out[1]};
    conn_out = is32 & output_route_jumper & out[2];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      outs <= 2'b00;
      external_counter_connector_out <= 1'b0;
    end else begin
      outs <= next_outs;
      external_counter_connector_out <= conn_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status, mask and interrupt

  // Count-up is the final stage's terminal count; overrun is a count-up
  // that arrives while the previous one is still unacknowledged
  always_comb begin
    ev = 5'h00;
    ev[ctc_pkg::ST_CU] = tc[2];
    ev[ctc_pkg::ST_OVR] = tc[2] & stat[ctc_pkg::ST_CU];
    ev[ctc_pkg::ST_TC0 +: 3] = tc;
    clr = 5'h00;
    if (wr && paddr == ctc_pkg::OFF_STAT && pstrb[0]) begin
      clr = pwdata[4:0];
    end
    // A new event wins over a clear in the same cycle
    next_stat = (stat & ~clr) | ev;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat <= ctc_pkg::STAT_RST;
    end else begin
      stat <= next_stat;
    end
  end

  assign irq = |(stat & mask);

endmodule // ctc_unit
`default_nettype wire

// File: dv/ctc_unit_monitor.sv
// Checker on the counter unit's bus, interrupt and connector ports
`timescale 1ns/1ps
`default_nettype none
module ctc_unit_monitor (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Jumpers, connector and interrupt
  input wire logic [1:0] chain_jumper,
  input wire logic output_route_jumper,
  input wire logic external_counter_connector_clk,
  input wire logic external_counter_connector_gate,
  input wire logic external_counter_connector_out,
  input wire logic irq
);
  logic acc;
  logic [4:0] mask_sh;
  logic [4:0] next_mask_sh;
  logic [3:0] quiet;
  logic [3:0] next_quiet;
  logic [1:0] ext_d;
  logic [1:0] next_ext_d;

  ////////////////////////////////////////////////////////////////////////
  // Access phase of any transfer
  assign acc = psel && penable;

  // Mask copy, and quiet time since connector or bus activity
  always_comb begin
    next_mask_sh = mask_sh;
    if (acc && pwrite && paddr == ctc_pkg::OFF_MASK && pstrb[0]) begin
      next_mask_sh = pwdata[4:0];
    end
    next_ext_d = {external_counter_connector_clk,
                  external_counter_connector_gate};
    // Saturates so a long idle never wraps back to zero
    next_quiet = (quiet == 4'hF) ? quiet : quiet + 4'h1;
    if (psel || chain_jumper != 2'b01 || ext_d != next_ext_d) begin
      next_quiet = 4'h0;
    end
  end

  // Helper registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_sh <= 5'h00;
      quiet <= 4'h0;
      ext_d <= 2'h0;
    end else begin
      mask_sh <= next_mask_sh;
      quiet <= next_quiet;
      ext_d <= next_ext_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_zero_wait: assert property (psel |-> pready)
    else $error("pready low during a transfer");
  a_err_unmapped: assert property (acc |->
    pslverr == (paddr > 8'h1C || paddr[1:0] != 2'b00))
    else $error("pslverr does not match the address map");
  a_unmapped_zero: assert property (acc && pslverr && !pwrite |->
    prdata == 32'h0000_0000)
    else $error("unmapped read returned data");
  a_cnt_width: assert property (
    acc && !pwrite && paddr == ctc_pkg::OFF_CNT0 |-> prdata[31:16] == 16'h0)
    else $error("stage count wider than 16 bits");
  a_outs_width: assert property (
    acc && !pwrite && paddr == ctc_pkg::OFF_OUTS |-> prdata[31:2] == 30'h0)
    else $error("output capture holds more than two bits");
  a_mask_read: assert property (
    acc && !pwrite && paddr == ctc_pkg::OFF_MASK |->
    prdata == {27'h0, mask_sh})
    else $error("mask read differs from last write");
  a_irq_masked: assert property (irq |-> mask_sh != 5'h00)
    else $error("irq high with every source masked");
  a_route_gated: assert property (
    !(chain_jumper inside {2'b01, 2'b10}) || !output_route_jumper |=>
    !external_counter_connector_out)
    else $error("connector output driven while not routed");
  a_ext_quiet: assert property (
    quiet == 4'hF |-> $stable(external_counter_connector_out))
    else $error("connector output moved with no external clock");
endmodule // ctc_unit_monitor

bind ctc_unit ctc_unit_monitor mon (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
  .chain_jumper, .output_route_jumper, .external_counter_connector_clk,
  .external_counter_connector_gate, .external_counter_connector_out, .irq);
`default_nettype wire

// File: dv/ctc_ext_src.sv
// Behavioural external clock and gate source on the counter connector
`timescale 1ns/1ps
`default_nettype none
module ctc_ext_src (
  // Clock
  input wire logic pclk,
  // Connector signals
  output logic ext_clk,
  output logic ext_gate
);
  // Clock rests low between bursts; it never runs free
  initial begin
    ext_clk = 1'b0;
    ext_gate = 1'b0;
  end

  // Pulses 3 cycles high, 3 low, slow enough for the edge detector
  task automatic pulses(input int n);
    repeat (n) begin
      ext_clk <= 1'b1;
      repeat (3) @(posedge pclk);
      ext_clk <= 1'b0;
      repeat (3) @(posedge pclk);
    end
  endtask

  // Gate level, held until changed
  task automatic gate(input logic g);
    ext_gate <= g;
  endtask
endmodule // ctc_ext_src
`default_nettype wire

// File: dv/test_ctc_unit.sv
// Self-checking bench for the jumper-chained counter unit
`timescale 1ns/1ps
`default_nettype none
module test_ctc_unit;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [3:0] strb;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] jmp;
  logic route;
  logic eclk;
  logic egate;
  logic cout;
  logic irq;
  int n_mismatch = 0;
  int tests_run = 0;

  ctc_unit dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(strb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chain_jumper(jmp), .output_route_jumper(route),
    .external_counter_connector_clk(eclk),
    .external_counter_connector_gate(egate),
    .external_counter_connector_out(cout), .irq(irq));
  ctc_ext_src src (.pclk(pclk), .ext_clk(eclk), .ext_gate(egate));

  ////////////////////////////////////////////////////////////////////////
  // 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic results();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // Jumpers change only while reset is held
  task automatic do_reset(input logic [1:0] j, input logic r);
    presetn <= 1'b0;
    jmp <= j;
    route <= r;
    cyc(5);
    presetn <= 1'b1;
    cyc(1);
  endtask

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the watchdog ends a wait for the slave's answer
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask

  function automatic logic [31:0] ctrl(input logic g,
      input ctc_pkg::ctc_mode_t m2, m1, m0);
    return {23'h000000, g, 2'b00, m2, m1, m0};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Reset values, mask width, unmapped address
  task automatic t_regs();
    logic [31:0] d;
    apb(1'b0, ctc_pkg::OFF_STAT, 32'h0, d);
    chk("stat_reset", 32'h0000_0000, d);
    wr(ctc_pkg::OFF_MASK, 32'hFFFF_FFFF);
    apb(1'b0, ctc_pkg::OFF_MASK, 32'h0, d);
    chk("mask_width", 32'h0000_001F, d);
    // Low byte strobed off: the mask must keep its value
    strb <= 4'hE;
    wr(ctc_pkg::OFF_MASK, 32'h0000_0000);
    strb <= 4'hF;
    apb(1'b0, ctc_pkg::OFF_MASK, 32'h0, d);
    chk("mask_strobe", 32'h0000_001F, d);
    wr(ctc_pkg::OFF_MASK, 32'h0000_0000);
    apb(1'b0, 8'h20, 32'h0, d);
    chk("unmapped_err", 32'h1, {31'h0, pslverr});
  endtask

  // Stage 0 counts at 4 MHz: about ten ticks in 250 cycles
  task automatic t_src();
    logic [31:0] d;
    wr(ctc_pkg::OFF_CTRL, ctrl(1'b1, ctc_pkg::CTC_MODE_TERM,
       ctc_pkg::CTC_MODE_TERM, ctc_pkg::CTC_MODE_TERM));
    wr(ctc_pkg::OFF_CNT0, 32'h0000_0100);
    cyc(250);
    apb(1'b0, ctc_pkg::OFF_CNT0, 32'h0, d);
    tests_run++;
    if ((d >= 32'h0000_00F5 && d <= 32'h0000_00F9) !== 1'b1) begin
      n_mismatch++;
      $display("CHECK FAILED cnt0_rate expected F5..F9 seen %h", d);
    end
  endtask

  // Cascade of rate generators, software gate, flags and interrupt
  task automatic t_casc();
    logic [31:0] d;
    do_reset(2'b00, 1'b0);
    wr(ctc_pkg::OFF_CTRL, ctrl(1'b0, ctc_pkg::CTC_MODE_RATE,
       ctc_pkg::CTC_MODE_RATE, ctc_pkg::CTC_MODE_RATE));
    wr(ctc_pkg::OFF_CNT0, 32'h2);
    wr(ctc_pkg::OFF_CNT1, 32'h2);
    wr(ctc_pkg::OFF_CNT2, 32'h2);
    cyc(800);
    apb(1'b0, ctc_pkg::OFF_STAT, 32'h0, d);
    chk("stat_gate_low", 32'h0, d);
    wr(ctc_pkg::OFF_CTRL, ctrl(1'b1, ctc_pkg::CTC_MODE_RATE,
       ctc_pkg::CTC_MODE_RATE, ctc_pkg::CTC_MODE_RATE));
    for (int i = 0; i < 80 && d[1] !== 1'b1; i++) begin
      cyc(20);
      apb(1'b0, ctc_pkg::OFF_STAT, 32'h0, d);
    end
    chk("stat_cu_ovr", 32'h3, {30'h0, d[1:0]});
    chk("irq_masked", 32'h0, {31'h0, irq});
    wr(ctc_pkg::OFF_MASK, 32'h3);
    chk("irq_raised", 32'h1, {31'h0, irq});
    // Halt first so no new terminal count races the clear
    wr(ctc_pkg::OFF_CTRL, 32'h0);
    cyc(300);
    wr(ctc_pkg::OFF_STAT, 32'h1F);
    apb(1'b0, ctc_pkg::OFF_STAT, 32'h0, d);
    chk("stat_cleared", 32'h0, d);
    chk("irq_cleared", 32'h0, {31'h0, irq});
    // One-shot on stage 0 waits for a software gate edge
    wr(ctc_pkg::OFF_CTRL, ctrl(1'b0, ctc_pkg::CTC_MODE_TERM,
       ctc_pkg::CTC_MODE_TERM, ctc_pkg::CTC_MODE_ONESHOT));
    wr(ctc_pkg::OFF_CNT0, 32'h3);
    cyc(150);
    apb(1'b0, ctc_pkg::OFF_STAT, 32'h0, d);
    chk("shot_idle", 32'h0, {31'h0, d[2]});
    wr(ctc_pkg::OFF_CTRL, ctrl(1'b1, ctc_pkg::CTC_MODE_TERM,
       ctc_pkg::CTC_MODE_TERM, ctc_pkg::CTC_MODE_ONESHOT));
    cyc(150);
    apb(1'b0, ctc_pkg::OFF_CNT0, 32'h0, d);
    chk("shot_count", 32'h0, d);
    apb(1'b0, ctc_pkg::OFF_STAT, 32'h0, d);
    chk("shot_tc", 32'h1, {31'h0, d[2]});
  endtask

  // External 32-bit pair: connector clock and gate, low half first
  task automatic t_ext32();
    logic [31:0] d;
    do_reset(2'b01, 1'b1);
    src.gate(1'b0);
    wr(ctc_pkg::OFF_CTRL, 32'h0);
    wr(ctc_pkg::OFF_CNT1, 32'h4);
    wr(ctc_pkg::OFF_CNT2, 32'h5);
    src.pulses(1);
    cyc(20);
    apb(1'b0, ctc_pkg::OFF_CNT32, 32'h0, d);
    chk("low_loaded", 32'h4, {16'h0, d[15:0]});
    src.pulses(2);
    cyc(20);
    apb(1'b0, ctc_pkg::OFF_CNT32, 32'h0, d);
    chk("ext_gate_low", 32'h4, {16'h0, d[15:0]});
    src.gate(1'b1);
    cyc(2);
    src.pulses(4);
    cyc(20);
    apb(1'b0, ctc_pkg::OFF_CNT32, 32'h0, d);
    chk("cnt32", 32'h0005_0000, d);
    apb(1'b0, ctc_pkg::OFF_OUTS, 32'h0, d);
    chk("outs_low", 32'h1, {31'h0, d[0]});
    chk("conn_low", 32'h0, {31'h0, cout});
    wr(ctc_pkg::OFF_CTRL, ctrl(1'b0, ctc_pkg::CTC_MODE_ONESHOT,
       ctc_pkg::CTC_MODE_TERM, ctc_pkg::CTC_MODE_TERM));
    wr(ctc_pkg::OFF_CNT2, 32'h5);
    cyc(10);
    chk("conn_routed", 32'h1, {31'h0, cout});
  endtask

  // Gated 32-bit pair: clocked by stage 0, gate from the connector
  task automatic t_gate32();
    logic [31:0] d;
    do_reset(2'b10, 1'b1);
    src.gate(1'b0);
    wr(ctc_pkg::OFF_CTRL, ctrl(1'b1, ctc_pkg::CTC_MODE_TERM,
       ctc_pkg::CTC_MODE_TERM, ctc_pkg::CTC_MODE_RATE));
    wr(ctc_pkg::OFF_CNT0, 32'h2);
    wr(ctc_pkg::OFF_CNT1, 32'h3);
    cyc(600);
    apb(1'b0, ctc_pkg::OFF_CNT1, 32'h0, d);
    chk("gate32_held", 32'h3, d);
    src.gate(1'b1);
    cyc(600);
    apb(1'b0, ctc_pkg::OFF_CNT1, 32'h0, d);
    chk("gate32_done", 32'h0, d);
    apb(1'b0, ctc_pkg::OFF_OUTS, 32'h0, d);
    chk("gate32_out1", 32'h1, {31'h0, d[0]});
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    strb = 4'hF;
    jmp = 2'b00;
    route = 1'b0;
    do_reset(2'b00, 1'b0);
    t_regs();
    t_src();
    t_casc();
    t_ext32();
    t_gate32();
    results();
  end

  // Watchdog well beyond the expected few thousand cycles
  initial begin
    cyc(50000);
    n_mismatch++;
    results();
  end
endmodule // test_ctc_unit
`default_nettype wire
